// [core/fault_map.svh]
// Bit positions, encodings, widths and timing counts for the driver fault-protection block.
// Assumes a 100 MHz system clock; included by the package and the design.
`ifndef FAULT_MAP_SVH
`define FAULT_MAP_SVH
`define CLK_PERIOD_NS 10
// Deglitch times, selected by a two-bit setting
`define DEG_SEL0_NS 200
`define DEG_SEL1_NS 500
`define DEG_SEL2_NS 1000
`define DEG_SEL3_NS 2000
`define NS_TO_CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define NS_TO_CYC_DN(ns) ((ns) / `CLK_PERIOD_NS)
// Driver retry period after an overcurrent shutdown
`define DRV_RETRY_NS 5000000
`define DRV_RETRY_CYC `NS_TO_CYC_DN(`DRV_RETRY_NS)
// Lock retry time is (setting + 1) units
`define LOCK_RETRY_TIME_UNIT_NS 100000000
`define LOCK_RETRY_TIME_UNIT_CYC `NS_TO_CYC_DN(`LOCK_RETRY_TIME_UNIT_NS)
// Field positions inside the hard current-limit mode
`define HCL_DISABLE_BIT_HI 3
`define HCL_DISABLE_BIT_LO 0
`define HCL_RETRY_BIT 2
`define HCL_REPORT_MODE 4'h8
// Overcurrent mode encodings
`define OCM_LATCH 2'h0
`define OCM_RETRY 2'h1
`define OCM_REPORT 2'h2
`define OCM_OFF 2'h3
// Widths of the deglitch and retry counters
`define DEG_CNT_W 8
`define RETRY_CNT_W 26
`endif

// [core/fault_pkg.sv]
// Types shared by the fault-protection block and its bench.
// Assumes fault_map.svh sits in the include path.
`include "fault_map.svh"
package fault_pkg;
   // Comparator levels from the analog front end, all asynchronous
   typedef struct packed {
      logic vm_uvlo;
      logic avdd_uv;
      logic buck_uv;
      logic pump_uv;
      logic vm_over_lo;
      logic vm_over_hi;
      logic [5:0] fet_over;
      logic buck_hs_over;
      logic csa_over;
      logic temp_warn;
      logic temp_below_hys;
   } sense_t;
   typedef struct packed {
      logic driver_fault;
      logic controller_fault;
      logic pump_undervoltage_flag;
      logic overvoltage_flag;
      logic overcurrent_flag;
      logic [5:0] fet_oc_flag;
      logic hard_current_limit_flag;
      logic thermal_flag;
      logic thermal_warning_flag;
   } status_t;
   typedef enum logic [2:0] {
      ST_DRIVE = 3'h0,
      ST_ALL_OFF = 3'h1,
      ST_RECIRC = 3'h3,
      ST_HS_ON = 3'h2,
      ST_LS_ON = 3'h6
   } stage_t;
   typedef enum logic [1:0] {
      OC_IDLE = 2'h0,
      OC_SHUT = 2'h1,
      OC_WAIT = 2'h3
   } oc_state_t;
   typedef enum logic [1:0] {
      HL_IDLE = 2'h0,
      HL_LATCH = 2'h1,
      HL_RETRY = 2'h3,
      HL_REPORT = 2'h2
   } hl_state_t;
endpackage : fault_pkg

// [core/fault_protect.sv]
// Fault detection and response for a three-phase integrated FET driver.
// Assumes analog comparators deliver raw levels and the host pulses fault_clear.
`include "fault_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Motor supply undervoltage: FETs and pump off, reset
// - Analog supply undervoltage: FETs and pump off, reset
// - Buck undervoltage: buck switches off, reset
// - Pump undervoltage: FETs off, pin low, auto-resume
// - Pump undervoltage flag sticky until clear
// - Overvoltage: FETs off, pin low, sticky flag
// - Overvoltage disabled when enable is zero
// - Threshold select picks 22 V or 34 V
// - Overcurrent needs deglitch; mode sets response
// - Mode 00: latched shutdown until clear
// - Mode 01: retry, driver fault auto-clears
// - Mode 10: report only, clear command
// - Mode 11: ignore overcurrent entirely
// - Buck overcurrent after deglitch: buck off, reset
// - Current limit needs sense amp deglitch
// - Latched limit modes set stage, pin low
// - Latched limit flags resume only after clear
// - Retry limit modes resume, flags cleared
// - Mode 1000: report only, flags until clear
// - Modes 1xx1: ignore current limit
// - Thermal warning reported: pin low only
// - Warning flag clears when cool and commanded
module fault_protect #(
   parameter int DRV_RETRY_CYCLES = `DRV_RETRY_CYC,
   parameter int LOCK_RETRY_UNIT_CYCLES = `LOCK_RETRY_TIME_UNIT_CYC
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Analog comparator levels
   input wire fault_pkg::sense_t sense,
   // Configuration
   input wire logic overvoltage_enable,
   input wire logic overvoltage_threshold_select,
   input wire logic [1:0] overcurrent_mode,
   input wire logic [1:0] overcurrent_deglitch,
   input wire logic [3:0] hard_current_limit_mode,
   input wire logic [1:0] hard_current_limit_deglitch,
   input wire logic [1:0] lock_retry_time,
   input wire logic thermal_warning_report_enable,
   input wire logic fault_clear,
   // Responses
   output logic fault_out_n,
   output fault_pkg::stage_t stage,
   output logic pump_enable,
   output logic buck_off,
   output logic device_reset_req,
   output fault_pkg::status_t status
);
   localparam int DW = `DEG_CNT_W;
   localparam int RW = `RETRY_CNT_W;
   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers and clear-pulse shaping
   fault_pkg::sense_t s1_r, s2_r;
   logic clr_d1_r, clr_d2_r, clr_d3_r, clr_pulse;
   // Host may hold the bit high; only the rising edge counts as a command
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= '0;
         s2_r <= '0;
         clr_d1_r <= 1'b0;
         clr_d2_r <= 1'b0;
         clr_d3_r <= 1'b0;
      end else begin
         s1_r <= sense;
         s2_r <= s1_r;
         clr_d1_r <= fault_clear;
         clr_d2_r <= clr_d1_r;
         clr_d3_r <= clr_d2_r;
      end
   end
   assign clr_pulse = clr_d2_r & ~clr_d3_r;
   ////////////////////////////////////////////////////////////////////////////
   // Deglitch filters: six FETs, buck high side, sense amplifier
   function automatic logic [DW-1:0] deg_cycles(input logic [1:0] sel);
      case (sel)
         2'h0: deg_cycles = DW'(`NS_TO_CYC_UP(`DEG_SEL0_NS));
         2'h1: deg_cycles = DW'(`NS_TO_CYC_UP(`DEG_SEL1_NS));
         2'h2: deg_cycles = DW'(`NS_TO_CYC_UP(`DEG_SEL2_NS));
         default: deg_cycles = DW'(`NS_TO_CYC_UP(`DEG_SEL3_NS));
      endcase
   endfunction
   logic [7:0] raw_over, deg_evt;
   logic [7:0][DW-1:0] deg_lim;
   assign raw_over = {s2_r.csa_over, s2_r.buck_hs_over, s2_r.fet_over};
   generate
      for (genvar gi = 0; gi < 8; gi++) begin : g_deg
         logic [DW-1:0] cnt_r, cnt_nxt;
         assign deg_lim[gi] = (gi == 7) ? deg_cycles(hard_current_limit_deglitch)
                                        : deg_cycles(overcurrent_deglitch);
         // Saturates one past the limit so the event means strictly longer
         always_comb begin
            cnt_nxt = cnt_r;
            if (!raw_over[gi]) cnt_nxt = '0;
            else if (cnt_r <= deg_lim[gi]) cnt_nxt = cnt_r + DW'(1);
         end
         always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) cnt_r <= '0;
            else cnt_r <= cnt_nxt;
         end
         assign deg_evt[gi] = cnt_r > deg_lim[gi];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // Level-driven conditions
   logic rst_evt, pump_act, ov_act, oc_any, oc_seen, hl_evt, hl_off, hl_report;
   assign rst_evt = s2_r.vm_uvlo | s2_r.avdd_uv | s2_r.buck_uv | deg_evt[6];
   assign pump_act = s2_r.pump_uv;
   assign ov_act = overvoltage_enable &
                   (overvoltage_threshold_select ? s2_r.vm_over_hi : s2_r.vm_over_lo);
   assign oc_any = |deg_evt[5:0];
   assign oc_seen = oc_any & (overcurrent_mode != `OCM_OFF);
   assign hl_off = hard_current_limit_mode[`HCL_DISABLE_BIT_HI] &
                   hard_current_limit_mode[`HCL_DISABLE_BIT_LO];
   assign hl_evt = deg_evt[7] & ~hl_off;
   assign hl_report = hard_current_limit_mode[`HCL_DISABLE_BIT_HI];

   ////////////////////////////////////////////////////////////////////////////
   // Overcurrent and current-limit state machines
   fault_pkg::oc_state_t oc_r, oc_nxt;
   fault_pkg::hl_state_t hl_r, hl_nxt;
   logic [RW-1:0] oc_cnt_r, oc_cnt_nxt, hl_cnt_r, hl_cnt_nxt, hl_lim;
   logic oc_expire, hl_expire;
   assign hl_lim = RW'(LOCK_RETRY_UNIT_CYCLES) * RW'({1'b0, lock_retry_time} + 3'h1);
   assign oc_expire = (oc_r == fault_pkg::OC_WAIT) && (oc_cnt_r == RW'(DRV_RETRY_CYCLES - 1));
   assign hl_expire = (hl_r == fault_pkg::HL_RETRY) && (hl_cnt_r == hl_lim - RW'(1));
   always_comb begin
      oc_nxt = oc_r;
      oc_cnt_nxt = '0;
      case (oc_r)
         fault_pkg::OC_IDLE: begin
            if (oc_seen && overcurrent_mode == `OCM_LATCH) oc_nxt = fault_pkg::OC_SHUT;
            else if (oc_seen && overcurrent_mode == `OCM_RETRY) oc_nxt = fault_pkg::OC_WAIT;
         end
         fault_pkg::OC_SHUT: begin
            if (clr_pulse && !oc_any) oc_nxt = fault_pkg::OC_IDLE;
         end
         fault_pkg::OC_WAIT: begin
            oc_cnt_nxt = oc_cnt_r + RW'(1);
            if (oc_expire) oc_nxt = fault_pkg::OC_IDLE;
         end
         default: oc_nxt = fault_pkg::OC_IDLE;
      endcase
      if (rst_evt) oc_nxt = fault_pkg::OC_IDLE;
   end
   always_comb begin
      hl_nxt = hl_r;
      hl_cnt_nxt = '0;
      case (hl_r)
         fault_pkg::HL_IDLE: begin
            if (hl_evt && hl_report) hl_nxt = fault_pkg::HL_REPORT;
            else if (hl_evt && hard_current_limit_mode[`HCL_RETRY_BIT])
               hl_nxt = fault_pkg::HL_RETRY;
            else if (hl_evt) hl_nxt = fault_pkg::HL_LATCH;
         end
         fault_pkg::HL_LATCH, fault_pkg::HL_REPORT: begin
            if (clr_pulse && !deg_evt[7]) hl_nxt = fault_pkg::HL_IDLE;
         end
         fault_pkg::HL_RETRY: begin
            hl_cnt_nxt = hl_cnt_r + RW'(1);
            if (hl_expire) hl_nxt = fault_pkg::HL_IDLE;
         end
         default: hl_nxt = fault_pkg::HL_IDLE;
      endcase
      if (rst_evt) hl_nxt = fault_pkg::HL_IDLE;
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         oc_r <= fault_pkg::OC_IDLE;
         hl_r <= fault_pkg::HL_IDLE;
         oc_cnt_r <= '0;
         hl_cnt_r <= '0;
      end else begin
         oc_r <= oc_nxt;
         hl_r <= hl_nxt;
         oc_cnt_r <= oc_cnt_nxt;
         hl_cnt_r <= hl_cnt_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status; a set in the same cycle as a clear command wins, but a reset event clears everything
   fault_pkg::status_t st_r, st_nxt;
   logic tw_act_r, tw_act_nxt, cool;
   assign cool = s2_r.temp_below_hys;
   always_comb begin
      st_nxt = st_r;
      tw_act_nxt = tw_act_r;
      if (clr_pulse) begin
         if (!pump_act) st_nxt.pump_undervoltage_flag = 1'b0;
         if (!ov_act) st_nxt.overvoltage_flag = 1'b0;
         if (!oc_any) begin
            st_nxt.overcurrent_flag = 1'b0;
            st_nxt.fet_oc_flag = '0;
         end
         if (!pump_act && !ov_act && !oc_any && oc_r == fault_pkg::OC_IDLE)
            st_nxt.driver_fault = 1'b0;
         if (!deg_evt[7] && hl_r != fault_pkg::HL_RETRY) begin
            st_nxt.controller_fault = 1'b0;
            st_nxt.hard_current_limit_flag = 1'b0;
         end
         if (cool) begin
            st_nxt.thermal_warning_flag = 1'b0;
            st_nxt.thermal_flag = 1'b0;
         end
      end
      if (oc_expire) st_nxt.driver_fault = 1'b0;
      if (hl_expire) begin
         st_nxt.controller_fault = 1'b0;
         st_nxt.hard_current_limit_flag = 1'b0;
      end
      if (cool) tw_act_nxt = 1'b0;
      if (pump_act) begin
         st_nxt.driver_fault = 1'b1;
         st_nxt.pump_undervoltage_flag = 1'b1;
      end
      if (ov_act) begin
         st_nxt.driver_fault = 1'b1;
         st_nxt.overvoltage_flag = 1'b1;
      end
      if (oc_seen) begin
         st_nxt.driver_fault = 1'b1;
         st_nxt.overcurrent_flag = 1'b1;
         st_nxt.fet_oc_flag = st_r.fet_oc_flag | deg_evt[5:0];
      end
      if (hl_evt && hl_r != fault_pkg::HL_RETRY) begin
         st_nxt.controller_fault = 1'b1;
         st_nxt.hard_current_limit_flag = 1'b1;
      end
      if (thermal_warning_report_enable && s2_r.temp_warn) begin
         tw_act_nxt = 1'b1;
         st_nxt.thermal_flag = 1'b1;
         st_nxt.thermal_warning_flag = 1'b1;
      end
      if (rst_evt) begin
         st_nxt = '0;
         tw_act_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         tw_act_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tw_act_r <= tw_act_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Output stage, fault pin and supply controls, all registered
   fault_pkg::stage_t stage_r, stage_nxt;
   logic pin_low_nxt, pin_low_r, pump_en_nxt, pump_en_r, buck_off_r, rst_req_r;
   always_comb begin
      stage_nxt = fault_pkg::ST_DRIVE;
      if (hl_r == fault_pkg::HL_LATCH || hl_r == fault_pkg::HL_RETRY) begin
         case (hard_current_limit_mode[1:0])
            2'h0: stage_nxt = fault_pkg::ST_ALL_OFF;
            2'h1: stage_nxt = fault_pkg::ST_RECIRC;
            2'h2: stage_nxt = fault_pkg::ST_HS_ON;
            default: stage_nxt = fault_pkg::ST_LS_ON;
         endcase
      end
      // Supply and overcurrent shutdowns override any braking choice
      if (rst_evt || pump_act || ov_act || oc_r != fault_pkg::OC_IDLE)
         stage_nxt = fault_pkg::ST_ALL_OFF;
      pin_low_nxt = pump_act | ov_act | (oc_r != fault_pkg::OC_IDLE) | tw_act_nxt |
                    (hl_r != fault_pkg::HL_IDLE) |
                    (st_r.overcurrent_flag & (overcurrent_mode == `OCM_REPORT));
      pump_en_nxt = ~(s2_r.vm_uvlo | s2_r.avdd_uv);
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         stage_r <= fault_pkg::ST_ALL_OFF;
         pin_low_r <= 1'b0;
         pump_en_r <= 1'b0;
         buck_off_r <= 1'b0;
         rst_req_r <= 1'b0;
      end else begin
         stage_r <= stage_nxt;
         pin_low_r <= pin_low_nxt;
         pump_en_r <= pump_en_nxt;
         buck_off_r <= s2_r.buck_uv | deg_evt[6];
         rst_req_r <= rst_evt;
      end
   end
   assign stage = stage_r;
   assign fault_out_n = ~pin_low_r;
   assign pump_enable = pump_en_r;
   assign buck_off = buck_off_r;
   assign device_reset_req = rst_req_r;
   assign status = st_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   reset_req_a: assert property (rst_evt |=> device_reset_req && status == '0)
      else $error("reset event did not request reset and clear status");
   buck_off_a: assert property (deg_evt[6] |=> buck_off && device_reset_req)
      else $error("buck overcurrent did not turn buck off");
   pump_off_a: assert property (pump_act |=> stage == fault_pkg::ST_ALL_OFF && !fault_out_n)
      else $error("pump undervoltage did not shut FETs and pull pin");
   pump_sticky_a: assert property (status.pump_undervoltage_flag && !clr_pulse && !rst_evt
      |=> status.pump_undervoltage_flag)
      else $error("pump undervoltage flag not sticky");
   ov_sel_a: assert property (overvoltage_enable && overvoltage_threshold_select
      && s2_r.vm_over_hi && !rst_evt |=> status.overvoltage_flag)
      else $error("34 V threshold not honoured");
   ov_off_a: assert property (!overvoltage_enable |=> !$rose(status.overvoltage_flag))
      else $error("overvoltage acted while disabled");
   oc_latch_a: assert property (oc_r == fault_pkg::OC_SHUT && !clr_pulse && !rst_evt
      |=> oc_r == fault_pkg::OC_SHUT ##1 stage == fault_pkg::ST_ALL_OFF)
      else $error("latched overcurrent released without clear");
   oc_retry_a: assert property (oc_expire && !rst_evt && !oc_seen && !pump_act && !ov_act
      |=> oc_r == fault_pkg::OC_IDLE && !status.driver_fault)
      else $error("retry expiry did not resume and clear driver fault");
   oc_ignore_a: assert property ($rose(status.overcurrent_flag)
      |-> $past(overcurrent_mode) != `OCM_OFF)
      else $error("overcurrent reported in disabled mode");
   hl_stage_a: assert property (hl_r == fault_pkg::HL_LATCH && hard_current_limit_mode == 4'h2
      && !rst_evt && !pump_act && !ov_act && oc_r == fault_pkg::OC_IDLE
      |=> stage == fault_pkg::ST_HS_ON)
      else $error("latched limit did not set high-side brake");
   hl_report_a: assert property (hl_r == fault_pkg::HL_REPORT |-> !fault_out_n
      || $past(hl_r) != fault_pkg::HL_REPORT)
      else $error("report mode lost pin indication");
   tw_pin_a: assert property (tw_act_r |-> !fault_out_n)
      else $error("thermal warning did not pull pin");
   oc_retry_c: cover property (oc_r == fault_pkg::OC_WAIT ##1 oc_r == fault_pkg::OC_IDLE);
   hl_latch_c: cover property (hl_r == fault_pkg::HL_LATCH ##1 hl_r == fault_pkg::HL_IDLE);
   tw_clear_c: cover property ($fell(status.thermal_warning_flag));
endmodule // fault_protect

// [tb/fault_host.sv]
// Host controller model that issues the clear-fault command.
// Assumes the bench requests a clear with a one-cycle clear_req pulse.
module fault_host (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Bench request
   input wire logic clear_req,
   // Command to the device
   output logic fault_clear
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] hold_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Clear pulse stays up two cycles so the synchroniser cannot miss it, then
   // stays low at least one cycle before another request counts
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hold_r <= 2'h0;
         fault_clear <= 1'b0;
      end else if (clear_req && hold_r == 2'h0 && !fault_clear) begin
         hold_r <= 2'h2;
         fault_clear <= 1'b1;
      end else if (hold_r != 2'h0) begin
         hold_r <= hold_r - 2'h1;
         fault_clear <= (hold_r != 2'h1);
      end
   end
endmodule // fault_host

// [tb/tb.sv]
// Self-checking bench for the fault-protection block.
// Assumes shortened retry counts: 16 cycles driver retry, 8 cycles lock retry unit.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   fault_pkg::sense_t sense = '0;
   logic ov_en = 1'b1, ov_sel = 1'b0, warn_rep = 1'b0, clear_req = 1'b0, fault_clear;
   logic [1:0] oc_mode = 2'h3, oc_deg = 2'h0, hl_deg = 2'h0, lock_rt = 2'h0;
   logic [3:0] hl_mode = 4'h9;
   logic fault_out_n, pump_enable, buck_off, device_reset_req;
   fault_pkg::stage_t stage;
   fault_pkg::status_t status;
   int miscompares = 0;
   int num_checks = 0;

   always #5 clk_sys = ~clk_sys;

   fault_protect #(.DRV_RETRY_CYCLES(16), .LOCK_RETRY_UNIT_CYCLES(8)) u_dut (
      .clk_sys(clk_sys), .rst_b(rst_b), .sense(sense), .overvoltage_enable(ov_en),
      .overvoltage_threshold_select(ov_sel), .overcurrent_mode(oc_mode),
      .overcurrent_deglitch(oc_deg), .hard_current_limit_mode(hl_mode),
      .hard_current_limit_deglitch(hl_deg), .lock_retry_time(lock_rt),
      .thermal_warning_report_enable(warn_rep), .fault_clear(fault_clear),
      .fault_out_n(fault_out_n), .stage(stage), .pump_enable(pump_enable),
      .buck_off(buck_off), .device_reset_req(device_reset_req), .status(status));

   fault_host u_host (.clk_sys(clk_sys), .rst_b(rst_b), .clear_req(clear_req),
      .fault_clear(fault_clear));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk_bit(string what, logic exp, logic got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic chk_vec(string what, logic [15:0] exp, logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   // Bounded wait for the fault pin to reach a level
   task automatic wait_pin(logic v);
      int n;
      n = 0;
      while (fault_out_n !== v && n < 400) begin
         cyc(1);
         n++;
      end
      if (fault_out_n !== v) begin
         miscompares++;
         $display("mismatch fault_out_n wait expected %b seen %b", v, fault_out_n);
         stop_test();
      end
      cyc(1);
   endtask

   task automatic do_clear();
      @(posedge clk_sys) clear_req <= 1'b1;
      @(posedge clk_sys) clear_req <= 1'b0;
      cyc(10);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_class();
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         sense.vm_uvlo <= (i == 0);
         sense.avdd_uv <= (i == 1);
         sense.buck_uv <= (i == 2);
         sense.buck_hs_over <= (i == 3);
         cyc(40);
         chk_bit("device_reset_req", 1'b1, device_reset_req);
         if (i < 2) chk_bit("pump_enable", 1'b0, pump_enable);
         if (i < 2) chk_vec("stage", fault_pkg::ST_ALL_OFF, stage);
         else chk_bit("buck_off", 1'b1, buck_off);
         @(posedge clk_sys) sense <= '0;
         cyc(40);
         chk_bit("device_reset_req", 1'b0, device_reset_req);
         chk_bit("pump_enable", 1'b1, pump_enable);
      end
      $display("done reset class");
   endtask

   task automatic t_pump();
      @(posedge clk_sys) sense.pump_uv <= 1'b1;
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_ALL_OFF, stage);
      chk_bit("driver_fault", 1'b1, status.driver_fault);
      @(posedge clk_sys) sense.pump_uv <= 1'b0;
      wait_pin(1'b1);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      chk_bit("pump_undervoltage_flag", 1'b1, status.pump_undervoltage_flag);
      do_clear();
      chk_bit("pump_undervoltage_flag", 1'b0, status.pump_undervoltage_flag);
      $display("done pump undervoltage");
   endtask

   task automatic t_overvoltage();
      @(posedge clk_sys) sense.vm_over_lo <= 1'b1;
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_ALL_OFF, stage);
      chk_bit("overvoltage_flag", 1'b1, status.overvoltage_flag);
      @(posedge clk_sys) sense.vm_over_lo <= 1'b0;
      wait_pin(1'b1);
      chk_bit("overvoltage_flag", 1'b1, status.overvoltage_flag);
      do_clear();
      chk_bit("overvoltage_flag", 1'b0, status.overvoltage_flag);
      // 22 V crossing alone must not trip the 34 V threshold
      @(posedge clk_sys) begin
         ov_sel <= 1'b1;
         sense.vm_over_lo <= 1'b1;
      end
      cyc(10);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) sense.vm_over_hi <= 1'b1;
      wait_pin(1'b0);
      chk_bit("overvoltage_flag", 1'b1, status.overvoltage_flag);
      @(posedge clk_sys) ov_en <= 1'b0;
      wait_pin(1'b1);
      do_clear();
      cyc(10);
      chk_bit("overvoltage_flag", 1'b0, status.overvoltage_flag);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      @(posedge clk_sys) sense <= '0;
      cyc(5);
      $display("done overvoltage");
   endtask

   task automatic t_oc_latch();
      @(posedge clk_sys) begin
         oc_mode <= 2'h0;
         oc_deg <= 2'h1;
         sense.fet_over <= 6'h04;
      end
      // Shorter than the 50 cycle deglitch: no event
      cyc(30);
      @(posedge clk_sys) sense.fet_over <= 6'h00;
      cyc(10);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) sense.fet_over <= 6'h04;
      wait_pin(1'b0);
      chk_vec("fet_oc_flag", 16'h0004, {10'h000, status.fet_oc_flag});
      chk_bit("overcurrent_flag", 1'b1, status.overcurrent_flag);
      @(posedge clk_sys) sense.fet_over <= 6'h00;
      cyc(40);
      chk_vec("stage", fault_pkg::ST_ALL_OFF, stage);
      do_clear();
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      $display("done overcurrent latch");
   endtask

   task automatic t_oc_other();
      @(posedge clk_sys) begin
         oc_mode <= 2'h1;
         oc_deg <= 2'h0;
         sense.fet_over <= 6'h20;
      end
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_ALL_OFF, stage);
      @(posedge clk_sys) sense.fet_over <= 6'h00;
      wait_pin(1'b1);
      chk_bit("driver_fault", 1'b0, status.driver_fault);
      chk_bit("overcurrent_flag", 1'b1, status.overcurrent_flag);
      do_clear();
      @(posedge clk_sys) begin
         oc_mode <= 2'h2;
         sense.fet_over <= 6'h01;
      end
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      chk_bit("driver_fault", 1'b1, status.driver_fault);
      do_clear();
      chk_bit("overcurrent_flag", 1'b1, status.overcurrent_flag);
      @(posedge clk_sys) sense.fet_over <= 6'h00;
      cyc(5);
      do_clear();
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) begin
         oc_mode <= 2'h3;
         sense.fet_over <= 6'h3f;
      end
      cyc(60);
      chk_vec("status", 16'h0000, status);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) sense.fet_over <= 6'h00;
      $display("done overcurrent modes");
   endtask

   task automatic t_limit();
      fault_pkg::stage_t brake [4];
      brake = '{fault_pkg::ST_ALL_OFF, fault_pkg::ST_RECIRC, fault_pkg::ST_HS_ON,
                fault_pkg::ST_LS_ON};
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys) begin
            hl_mode <= i[3:0];
            sense.csa_over <= 1'b1;
         end
         wait_pin(1'b0);
         chk_vec("stage", brake[i], stage);
         chk_bit("controller_fault", 1'b1, status.controller_fault);
         @(posedge clk_sys) sense.csa_over <= 1'b0;
         cyc(20);
         chk_bit("fault_out_n", 1'b0, fault_out_n);
         do_clear();
         chk_vec("stage", fault_pkg::ST_DRIVE, stage);
         chk_bit("hard_current_limit_flag", 1'b0, status.hard_current_limit_flag);
      end
      @(posedge clk_sys) begin
         hl_mode <= 4'h6;
         sense.csa_over <= 1'b1;
      end
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_HS_ON, stage);
      @(posedge clk_sys) sense.csa_over <= 1'b0;
      wait_pin(1'b1);
      chk_bit("hard_current_limit_flag", 1'b0, status.hard_current_limit_flag);
      @(posedge clk_sys) begin
         hl_mode <= 4'h8;
         sense.csa_over <= 1'b1;
      end
      wait_pin(1'b0);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      @(posedge clk_sys) sense.csa_over <= 1'b0;
      cyc(5);
      do_clear();
      chk_bit("controller_fault", 1'b0, status.controller_fault);
      @(posedge clk_sys) begin
         hl_mode <= 4'hf;
         sense.csa_over <= 1'b1;
      end
      cyc(60);
      chk_bit("hard_current_limit_flag", 1'b0, status.hard_current_limit_flag);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) sense.csa_over <= 1'b0;
      $display("done current limit");
   endtask

   task automatic t_thermal();
      @(posedge clk_sys) sense.temp_warn <= 1'b1;
      cyc(10);
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      @(posedge clk_sys) begin
         warn_rep <= 1'b1;
         sense.temp_below_hys <= 1'b0;
      end
      wait_pin(1'b0);
      chk_bit("thermal_flag", 1'b1, status.thermal_flag);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      @(posedge clk_sys) sense.temp_warn <= 1'b0;
      do_clear();
      chk_bit("thermal_warning_flag", 1'b1, status.thermal_warning_flag);
      @(posedge clk_sys) sense.temp_below_hys <= 1'b1;
      wait_pin(1'b1);
      do_clear();
      chk_bit("thermal_warning_flag", 1'b0, status.thermal_warning_flag);
      $display("done thermal warning");
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      sense.temp_below_hys = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b0;
      #1;
      chk_bit("fault_out_n", 1'b1, fault_out_n);
      chk_vec("status", 16'h0000, status);
      @(posedge clk_sys) rst_b <= 1'b1;
      cyc(5);
      chk_vec("stage", fault_pkg::ST_DRIVE, stage);
      t_reset_class();
      t_pump();
      t_overvoltage();
      t_oc_latch();
      t_oc_other();
      t_limit();
      t_thermal();
      stop_test();
   end
endmodule // tb
